// *** shared/rics_regs.vh ***
// register offsets, field positions, reset values and vector table constants
// assumes one 32-bit AHB-Lite slave, one register per aligned word
`ifndef RICS_REGS_VH
`define RICS_REGS_VH
// register byte offsets
`define RICS_OFS_STATUS     8'h00
`define RICS_OFS_PWR_CTRL   8'h04
`define RICS_OFS_ENABLES    8'h08
`define RICS_OFS_FLAGS      8'h0c
`define RICS_OFS_CORE       8'h10
`define RICS_OFS_WDOG_CFG   8'h14
`define RICS_OFS_DEBUG      8'h18
// reset status bit positions
`define RICS_ST_POWER_ON    7
`define RICS_ST_PIN         6
`define RICS_ST_WATCHDOG    5
`define RICS_ST_BAD_OPCODE  4
`define RICS_ST_BAD_ADDRESS 3
`define RICS_ST_LOW_VOLTAGE 1
// power control bit positions
`define RICS_PC_WARN_FLAG   7
`define RICS_PC_WARN_ACK    6
`define RICS_PC_WARN_IE     5
`define RICS_PC_DET_RST_EN  4
`define RICS_PC_STOP_DET_EN 3
`define RICS_PC_DET_EN      2
`define RICS_PC_THRESH      0
`define RICS_PC_RESET       8'h1c
// watchdog service bytes
`define RICS_SVC_FIRST      8'h55
`define RICS_SVC_SECOND     8'haa
// vector table
`define RICS_VEC_BASE       16'hffc0
`define RICS_VEC_LAST       5'h1f
`define RICS_VEC_SWI        5'h01
`define RICS_VEC_WARN       5'h03
`define RICS_VEC_T1_CH0     5'h05
`define RICS_VEC_T1_CH1     5'h06
`define RICS_VEC_T1_OVF     5'h0b
`define RICS_VEC_T2_CH0     5'h0c
`define RICS_VEC_T2_CH1     5'h0d
`define RICS_VEC_T2_OVF     5'h0e
`define RICS_VEC_SCI_ERR    5'h10
`define RICS_VEC_SCI_RX     5'h11
`define RICS_VEC_SCI_TX     5'h12
`define RICS_VEC_PORT_A     5'h14
`define RICS_VEC_PORT_B     5'h15
`define RICS_VEC_ADC        5'h17
`endif

// *** hdl/rics_top.v ***
// reset, interrupt and system control: event flags, vector select,
// low-voltage detect control, reset cause status and watchdog service
// assumes an AHB-Lite master on mclk; analog and event inputs are asynchronous
`timescale 1ns/1ps
`include "rics_regs.vh"
module rics_top #(
    parameter NSRC = 21
) (
    input  wire        mclk,
    input  wire        srst,
    input  wire        power_on_event,
    input  wire        reset_pin_event,
    input  wire        bad_opcode_event,
    input  wire        bad_address_event,
    input  wire        watchdog_timeout,
    input  wire        below_detect_level,
    input  wire        below_warn_level,
    input  wire [20:0] src_event,
    input  wire        core_mask,
    input  wire        core_ack,
    input  wire        stop_request,
    input  wire        deep_stop_request,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg         irq_to_core,
    output reg  [4:0]  irq_vector,
    output reg  [15:0] vector_addr,
    output reg         system_reset,
    output reg         watchdog_restart,
    output reg         detect_active,
    output reg         threshold_select,
    output reg         light_stop_mode,
    output reg         deep_stop_mode
);
    // source order in src_event/enables: 0 t1ch0,1 t1ch1,2 t1ovf,3 t2ch0,4 t2ch1,
    // 5 t2ovf,6 overrun,7 noise,8 framing,9 parity,10 idle,11 rxfull,12 break,
    // 13 rxedge,14 txempty,15 txcomplete,16 port a,17 port b,18 adc,19 swi,20 unused

    // map source index to its vector number
    function [4:0] src_vector;
        input [4:0] idx;
        begin
            case (idx)
                5'd0:    src_vector = `RICS_VEC_T1_CH0;
                5'd1:    src_vector = `RICS_VEC_T1_CH1;
                5'd2:    src_vector = `RICS_VEC_T1_OVF;
                5'd3:    src_vector = `RICS_VEC_T2_CH0;
                5'd4:    src_vector = `RICS_VEC_T2_CH1;
                5'd5:    src_vector = `RICS_VEC_T2_OVF;
                5'd6,5'd7,5'd8,5'd9:     src_vector = `RICS_VEC_SCI_ERR;
                5'd10,5'd11,5'd12,5'd13: src_vector = `RICS_VEC_SCI_RX;
                5'd14,5'd15: src_vector = `RICS_VEC_SCI_TX;
                5'd16:   src_vector = `RICS_VEC_PORT_A;
                5'd17:   src_vector = `RICS_VEC_PORT_B;
                5'd18:   src_vector = `RICS_VEC_ADC;
                5'd19:   src_vector = `RICS_VEC_SWI;
                default: src_vector = `RICS_VEC_LAST;
            endcase
        end
    endfunction

    // two-flop synchronisers for asynchronous inputs
    reg [27:0] sync_a;
    reg [27:0] sync_b;
    wire [27:0] async_in = {power_on_event, reset_pin_event, bad_opcode_event,
                            bad_address_event, watchdog_timeout, below_detect_level,
                            below_warn_level, src_event};
    always @(posedge mclk) begin
        if (srst) begin
            sync_a <= 28'h0;
            sync_b <= 28'h0;
        end else begin
            sync_a <= async_in;
            sync_b <= sync_a;
        end
    end
    wire        s_por   = sync_b[27];
    wire        s_pin   = sync_b[26];
    wire        s_bop   = sync_b[25];
    wire        s_bad   = sync_b[24];
    wire        s_wdto  = sync_b[23];
    wire        s_low   = sync_b[22];
    wire        s_warn  = sync_b[21];
    wire [20:0] s_event = sync_b[20:0];

    // registers
    reg [7:0]  reset_source_status;
    reg        warning_flag;
    reg        warning_irq_enable;
    reg        detect_reset_enable;
    reg        stop_detect_enable;
    reg        detect_enable;
    reg        pwr_written;
    reg [20:0] src_enable;
    reg [20:0] src_flag;
    reg [1:0]  watchdog_timeout_field;
    reg        wdog_written;
    reg        debug_force_reset;
    reg        svc_armed;
    reg        reset_hold;

    // bus address phase capture
    reg        dp_valid;
    reg        dp_write;
    reg [7:0]  dp_addr;
    wire       ap_take = hsel & hready & htrans[1];

    wire        watchdog_on = (watchdog_timeout_field != 2'b00);
    // with stop_detect_enable clear, detection drops in the very cycle a stop request arrives, so the
    // detect output never lags the stop-mode outputs by a cycle
    wire        det_on      = detect_enable & (~stop_request | stop_detect_enable);
    wire        wr_status   = dp_valid & dp_write & (dp_addr == `RICS_OFS_STATUS);
    wire [7:0]  wbyte       = hwdata[7:0];
    wire        bad_service = wr_status & watchdog_on & (wbyte != `RICS_SVC_FIRST)
                              & (wbyte != `RICS_SVC_SECOND);
    wire        wdog_reset  = (s_wdto & watchdog_on) | bad_service;
    wire        lv_reset    = det_on & detect_reset_enable & s_low;
    wire        any_reset   = s_por | s_pin | s_bop | s_bad | wdog_reset | lv_reset
                              | debug_force_reset;
    wire [20:0] pending     = src_flag & src_enable;

    // bus data phase: always zero wait states, okay response
    always @(posedge mclk) begin
        if (srst) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else if (hready) begin
            dp_valid <= ap_take;
            dp_write <= hwrite;
            dp_addr  <= {haddr[7:2], 2'b00};
        end
    end

    // read mux: address-phase registered read data
    reg [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h0;
        case ({haddr[7:2], 2'b00})
            `RICS_OFS_STATUS:   next_rdata = {24'h0, reset_source_status};
            `RICS_OFS_PWR_CTRL: next_rdata = {24'h0, warning_flag, 1'b0, warning_irq_enable,
                                    detect_reset_enable, stop_detect_enable,
                                    detect_enable, 1'b0, threshold_select};
            `RICS_OFS_ENABLES:  next_rdata = {11'h0, src_enable};
            `RICS_OFS_FLAGS:    next_rdata = {11'h0, src_flag};
            `RICS_OFS_CORE:     next_rdata = {16'h0, vector_addr};
            `RICS_OFS_WDOG_CFG: next_rdata = {30'h0, watchdog_timeout_field};
            default:            next_rdata = 32'h0;
        endcase
    end
    always @(posedge mclk) begin
        if (srst) begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (ap_take & ~hwrite)
                hrdata <= next_rdata;
        end
    end

    // reset cause capture and reset hold; status is read-only to the bus
    always @(posedge mclk) begin
        if (srst) begin
            reset_source_status <= 8'h82;
            reset_hold          <= 1'b0;
            system_reset        <= 1'b0;
        end else begin
            system_reset <= any_reset | (reset_hold & s_low);
            if (reset_hold & ~s_low)
                reset_hold <= 1'b0;
            if (s_por) begin
                reset_source_status <= 8'h82;
                reset_hold          <= 1'b1;
            end else if (lv_reset) begin
                reset_source_status[`RICS_ST_LOW_VOLTAGE] <= 1'b1;
                reset_source_status[6:2] <= 5'h0;
                reset_source_status[0]   <= 1'b0;
                reset_hold <= 1'b1;
            end else if (debug_force_reset) begin
                reset_source_status <= 8'h00;
            end else if (any_reset) begin
                reset_source_status <= {1'b0, s_pin, wdog_reset, s_bop, s_bad,
                                        3'b000};
            end
        end
    end

    // watchdog service sequence: 0x55 then 0xaa restarts the count
    always @(posedge mclk) begin
        if (srst) begin
            svc_armed        <= 1'b0;
            watchdog_restart <= 1'b0;
        end else begin
            watchdog_restart <= 1'b0;
            if (wr_status) begin
                svc_armed <= (wbyte == `RICS_SVC_FIRST);
                if (svc_armed & (wbyte == `RICS_SVC_SECOND))
                    watchdog_restart <= 1'b1;
            end
        end
    end

    // control register writes, write-once fields, debug force reset
    always @(posedge mclk) begin
        if (srst) begin
            warning_irq_enable     <= 1'b0;
            detect_reset_enable    <= 1'b1;
            stop_detect_enable     <= 1'b1;
            detect_enable          <= 1'b1;
            threshold_select       <= 1'b0;
            pwr_written            <= 1'b0;
            src_enable             <= 21'h0;
            watchdog_timeout_field <= 2'b11;
            wdog_written           <= 1'b0;
            debug_force_reset      <= 1'b0;
        end else begin
            debug_force_reset <= 1'b0;
            if (dp_valid & dp_write) begin
                case (dp_addr)
                    `RICS_OFS_PWR_CTRL: begin
                        warning_irq_enable <= wbyte[`RICS_PC_WARN_IE];
                        stop_detect_enable <= wbyte[`RICS_PC_STOP_DET_EN];
                        threshold_select   <= wbyte[`RICS_PC_THRESH];
                        if (~pwr_written) begin
                            detect_reset_enable <= wbyte[`RICS_PC_DET_RST_EN];
                            detect_enable       <= wbyte[`RICS_PC_DET_EN];
                            pwr_written         <= 1'b1;
                        end
                    end
                    `RICS_OFS_ENABLES: src_enable <= hwdata[20:0];
                    `RICS_OFS_WDOG_CFG: begin
                        if (~wdog_written) begin
                            watchdog_timeout_field <= hwdata[1:0];
                            wdog_written           <= 1'b1;
                        end
                    end
                    `RICS_OFS_DEBUG: debug_force_reset <= hwdata[0];
                    default: ;
                endcase
            end
        end
    end

    // event flags: set wins over write-one-to-clear; warning ack only if gone
    wire w1c_flags = dp_valid & dp_write & (dp_addr == `RICS_OFS_FLAGS);
    wire warn_ack  = dp_valid & dp_write & (dp_addr == `RICS_OFS_PWR_CTRL)
                     & wbyte[`RICS_PC_WARN_ACK];
    always @(posedge mclk) begin
        if (srst) begin
            src_flag     <= 21'h0;
            warning_flag <= 1'b0;
        end else begin
            src_flag <= (src_flag & ~(w1c_flags ? hwdata[20:0] : 21'h0))
                        | s_event;
            if (det_on & s_warn)
                warning_flag <= 1'b1;
            else if (warn_ack)
                warning_flag <= 1'b0;
        end
    end

    // priority select: lowest pending vector number wins
    reg [4:0] next_vec;
    reg       next_req;
    integer   i;
    always @(*) begin
        next_vec = `RICS_VEC_LAST;
        next_req = 1'b0;
        if (warning_flag & warning_irq_enable) begin
            next_vec = `RICS_VEC_WARN;
            next_req = 1'b1;
        end
        for (i = 0; i < NSRC; i = i + 1) begin
            if (pending[i] && (src_vector(i[4:0]) < next_vec || !next_req)) begin
                next_vec = src_vector(i[4:0]);
                next_req = 1'b1;
            end
        end
    end

    // request to core, gated by the global mask; vector address out
    always @(posedge mclk) begin
        if (srst) begin
            irq_to_core <= 1'b0;
            irq_vector  <= 5'h00;
            vector_addr <= `RICS_VEC_BASE + 16'h003e;
        end else begin
            irq_to_core <= next_req & ~core_mask & ~core_ack;
            irq_vector  <= next_vec;
            vector_addr <= `RICS_VEC_BASE
                           + {10'h0, (`RICS_VEC_LAST - next_vec), 1'b0};
        end
    end

    // stop mode steering and detector enable outputs
    always @(posedge mclk) begin
        if (srst) begin
            light_stop_mode <= 1'b0;
            deep_stop_mode  <= 1'b0;
            detect_active   <= 1'b0;
        end else begin
            light_stop_mode <= stop_request & (~deep_stop_request
                               | (stop_detect_enable & detect_enable));
            deep_stop_mode  <= stop_request & deep_stop_request
                               & ~(stop_detect_enable & detect_enable);
            detect_active   <= det_on;
        end
    end
endmodule // rics_top

// *** testbench/rics_top_sva.sv ***
// port-level assertions for the reset and interrupt control block
// assumes one clock mclk and synchronous active-high srst
`timescale 1ns/1ps
module rics_chk (
    input wire        mclk,
    input wire        srst,
    input wire        hsel,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire        irq_to_core,
    input wire [4:0]  irq_vector,
    input wire [15:0] vector_addr,
    input wire        system_reset,
    input wire        watchdog_restart,
    input wire        detect_active,
    input wire        light_stop_mode,
    input wire        deep_stop_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic ph_rd;
    logic ph_wr;
    logic aa_done;
    wire  st_sel = hsel && hready && htrans[1] && (haddr == 8'h00);
    wire  svc_ok = (hwdata[7:0] == 8'h55) || (hwdata[7:0] == 8'haa);
    // data phases of status accesses and the second service byte
    always @(posedge mclk) begin
        ph_rd   <= !srst && st_sel && !hwrite;
        ph_wr   <= !srst && st_sel && hwrite;
        aa_done <= !srst && ph_wr && (hwdata[7:0] == 8'haa);
    end
    property p_vec_addr; irq_to_core |-> vector_addr == 16'hffc0 + {10'h000, ~irq_vector, 1'b0}; endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("vector address mismatch");
    property p_vec_legal; irq_to_core |-> irq_vector inside {1,3,5,6,11,12,13,14,16,17,18,20,21,23}; endproperty
    a_vec_legal: assert property (p_vec_legal) else $error("unassigned vector");
    property p_st_zero; ph_rd |-> hrdata[2] == 1'b0 && hrdata[0] == 1'b0; endproperty
    a_st_zero: assert property (p_st_zero) else $error("status reserved bit set");
    property p_svc_safe; ph_wr && svc_ok && !system_reset |=> !system_reset; endproperty
    a_svc_safe: assert property (p_svc_safe) else $error("service byte reset");
    property p_restart; watchdog_restart |-> aa_done || $past(aa_done); endproperty
    a_restart: assert property (p_restart) else $error("restart without sequence");
    property p_pulse; watchdog_restart |=> !watchdog_restart; endproperty
    a_pulse: assert property (p_pulse) else $error("restart longer than a cycle");
    property p_stop_excl; !(light_stop_mode && deep_stop_mode); endproperty
    a_stop_excl: assert property (p_stop_excl) else $error("two stop modes");
    property p_deep_off; deep_stop_mode |-> !detect_active; endproperty
    a_deep_off: assert property (p_deep_off) else $error("detect on in deep stop");
    property p_rst_state; $fell(srst) |-> !irq_to_core && !system_reset && vector_addr == 16'hfffe; endproperty
    a_rst_state: assert property (p_rst_state) else $error("bad reset state");
    c_restart: cover property (watchdog_restart);
    c_sysrst: cover property (system_reset);
    c_warn: cover property (irq_to_core && irq_vector == 5'd3);
endmodule // rics_chk
bind rics_top rics_chk u_rics_chk (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .irq_to_core(irq_to_core), .irq_vector(irq_vector), .vector_addr(vector_addr),
    .system_reset(system_reset), .watchdog_restart(watchdog_restart),
    .detect_active(detect_active), .light_stop_mode(light_stop_mode),
    .deep_stop_mode(deep_stop_mode));

// *** testbench/rics_core_model.sv ***
// core-side model: takes requests, masks itself, latches the vector
// assumes request and vector outputs of the block on mclk
`timescale 1ns/1ps
module rics_core_model (
    input  wire        mclk,
    input  wire        srst,
    input  wire        irq_to_core,
    input  wire [4:0]  irq_vector,
    input  wire        return_from_trap,
    input  wire        slow,
    output logic       core_mask,
    output logic       core_ack,
    output logic [4:0] taken_vec,
    output logic [7:0] taken_cnt
);
    logic       busy;
    logic [2:0] wait_c;
    // set the mask, wait out the instruction and stacking, then fetch the vector
    always @(posedge mclk) begin
        core_ack <= 1'b0;
        if (srst) begin
            core_mask <= 1'b1;
            busy      <= 1'b0;
            taken_cnt <= 8'h00;
        end else if (busy && wait_c == 3'd0) begin
            core_ack  <= 1'b1;
            taken_vec <= irq_vector;
            taken_cnt <= taken_cnt + 8'h01;
            busy      <= 1'b0;
        end else if (busy) begin
            wait_c <= wait_c - 3'd1;
        end else if (irq_to_core && !core_mask) begin
            busy      <= 1'b1;
            core_mask <= 1'b1;
            wait_c    <= slow ? 3'd5 : 3'd0;
        end else if (return_from_trap) begin
            core_mask <= 1'b0;
        end
    end
endmodule // rics_core_model

// *** testbench/tb.sv ***
// self-checking bench: register tasks over AHB-Lite, core model on the far side
// assumes the bound checker and the core model file
`timescale 1ns/1ps
module tb;
    logic        mclk = 1'b0, srst = 1'b1, below_det = 1'b0, below_warn = 1'b0;
    logic        stop_req = 1'b0, deep_req = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        return_from_trap = 1'b0, slow = 1'b0;
    logic [4:0]  cause = 5'h00, v;
    logic [20:0] src_event = 21'h000000;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] hwdata = 32'h0, q;
    logic [4:0]  vmap [20];
    logic [7:0]  cexp [5] = '{8'h82, 8'h40, 8'h20, 8'h10, 8'h08};
    wire  [31:0] hrdata;
    wire         hreadyout, irq_to_core, core_mask, core_ack, system_reset, watchdog_restart;
    wire         detect_active, threshold_select, light_stop_mode, deep_stop_mode, hresp;
    wire  [4:0]  irq_vector, taken_vec;
    wire  [15:0] vector_addr;
    wire  [7:0]  taken_cnt;
    int          hist [32];
    int          err_count = 0, n_tests = 0, rs_cnt = 0, cyc = 0, i;
    rics_top u_rics_top (.mclk(mclk), .srst(srst), .power_on_event(cause[4]),
        .reset_pin_event(cause[3]), .watchdog_timeout(cause[2]), .bad_opcode_event(cause[1]),
        .bad_address_event(cause[0]), .below_detect_level(below_det),
        .below_warn_level(below_warn), .src_event(src_event), .core_mask(core_mask),
        .core_ack(core_ack), .stop_request(stop_req), .deep_stop_request(deep_req),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq_to_core(irq_to_core), .irq_vector(irq_vector),
        .vector_addr(vector_addr), .system_reset(system_reset),
        .watchdog_restart(watchdog_restart), .detect_active(detect_active),
        .threshold_select(threshold_select), .light_stop_mode(light_stop_mode),
        .deep_stop_mode(deep_stop_mode));
    rics_core_model u_rics_core_model (.mclk(mclk), .srst(srst), .irq_to_core(irq_to_core),
        .irq_vector(irq_vector), .return_from_trap(return_from_trap), .slow(slow), .core_mask(core_mask),
        .core_ack(core_ack), .taken_vec(taken_vec), .taken_cnt(taken_cnt));
    initial forever #10 mclk = ~mclk;
    // cycle ceiling and restart pulse count
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (watchdog_restart === 1'b1) rs_cnt <= rs_cnt + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            end_sim;
        end
    end
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one single transfer: address phase, then data phase
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        q = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
        chk("hresp", 0, hresp);
    endtask
    task rst_cycle;
        for (int k = 0; k < 10 && system_reset !== 1'b1; k++) @(posedge mclk);
        chk("reset_rise", 1, system_reset);
        for (int k = 0; k < 60 && system_reset !== 1'b0; k++) @(posedge mclk);
        chk("reset_fall", 0, system_reset);
        repeat (2) @(posedge mclk);
    endtask
    // raise events, reopen the core mask, collect the taken vector, clear flags
    task take(input logic [20:0] ev, input logic w, output logic [4:0] vo);
        logic [7:0] c0;
        c0 = taken_cnt;
        src_event <= ev; below_warn <= w;
        repeat (3) @(posedge mclk);
        src_event <= 21'h0; below_warn <= 1'b0;
        repeat (4) @(posedge mclk);
        return_from_trap <= 1'b1;
        @(posedge mclk);
        return_from_trap <= 1'b0;
        for (int k = 0; k < 40 && taken_cnt == c0; k++) @(posedge mclk);
        vo = taken_vec;
        chk("taken_count", c0 + 8'h01, taken_cnt);
        wr(8'h0c, 32'h1fffff);
        repeat (4) @(posedge mclk);
    endtask
    // vector that each source index must land on
    function automatic int exp_vec(input int n);
        case (n)
            0: return 5;
            1: return 6;
            2: return 11;
            3: return 12;
            4: return 13;
            5: return 14;
            6, 7, 8, 9: return 16;
            10, 11, 12, 13: return 17;
            14, 15: return 18;
            16: return 20;
            17: return 21;
            18: return 23;
            default: return 1;
        endcase
    endfunction
    function automatic int exp_cnt(input int n);
        case (n)
            16, 17: return 4;
            18: return 2;
            1, 5, 6, 11, 12, 13, 14, 20, 21, 23: return 1;
            default: return 0;
        endcase
    endfunction
    initial begin
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        chk("vector_addr", 32'hfffe, vector_addr);
        rd("status", 8'h00, 32'h82);
        rd("power_ctrl", 8'h04, 32'h1c);
        rd("watchdog_field", 8'h14, 32'h3);
        rd("unmapped", 8'h1c, 32'h0);
        wr(8'h00, 32'h55);
        wr(8'h00, 32'haa);
        repeat (3) @(posedge mclk);
        chk("restart_count", 1, rs_cnt);
        rd("status", 8'h00, 32'h82);
        $display("test reset and service done");
        wr(8'h08, 32'h1fffff);
        for (i = 0; i < 20; i++) begin
            take(21'h1 << i, 1'b0, vmap[i]);
            hist[vmap[i]]++;
            chk("vector_map", exp_vec(i), vmap[i]);
        end
        for (i = 0; i < 32; i++) chk("vector_use", exp_cnt(i), hist[i]);
        slow <= 1'b1;
        for (i = 0; i < 19; i++) begin
            take(21'h3 << i, 1'b0, v);
            chk("priority", exp_vec(i) < exp_vec(i+1) ? exp_vec(i) : exp_vec(i+1), v);
        end
        wr(8'h08, 32'h1ffffe);
        return_from_trap <= 1'b1; // open the core mask so only the local enable can hold the request
        @(posedge mclk);
        return_from_trap <= 1'b0;
        src_event <= 21'h1;
        repeat (20) @(posedge mclk);
        src_event <= 21'h0;
        chk("gated_request", 0, irq_to_core);
        rd("flags", 8'h0c, 32'h1);
        wr(8'h0c, 32'h1fffff);
        $display("test interrupts done");
        wr(8'h04, 32'h3d);
        repeat (2) @(posedge mclk);
        chk("threshold", 1, threshold_select);
        chk("detect_on", 1, detect_active);
        take(21'h0, 1'b1, v);
        chk("warn_vector", 3, v);
        rd("power_ctrl", 8'h04, 32'hbd);
        wr(8'h04, 32'h7d);
        rd("power_ctrl", 8'h04, 32'h3d);
        stop_req <= 1'b1; deep_req <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("light_stop", 1, light_stop_mode);
        chk("stop_detect", 1, detect_active);
        wr(8'h04, 32'h15);
        repeat (3) @(posedge mclk);
        chk("deep_stop", 1, deep_stop_mode);
        chk("stop_detect", 0, detect_active);
        stop_req <= 1'b0; deep_req <= 1'b0;
        below_det <= 1'b1;
        repeat (20) @(posedge mclk);
        chk("held_reset", 1, system_reset);
        below_det <= 1'b0;
        rst_cycle;
        rd("status", 8'h00, 32'h82);
        $display("test power control done");
        for (i = 0; i < 5; i++) begin
            cause <= 5'h10 >> i;
            repeat (4) @(posedge mclk);
            cause <= 5'h00;
            rst_cycle;
            rd("status", 8'h00, {24'h0, cexp[i]});
        end
        wr(8'h00, 32'h12);
        rst_cycle;
        rd("status", 8'h00, 32'h20);
        wr(8'h18, 32'h1);
        rst_cycle;
        rd("status", 8'h00, 32'h00);
        wr(8'h14, 32'h0);
        wr(8'h14, 32'h3);
        rd("watchdog_field", 8'h14, 32'h0);
        wr(8'h00, 32'h12);
        repeat (5) @(posedge mclk);
        chk("blocked_reset", 0, system_reset);
        $display("test reset causes done");
        end_sim;
    end
endmodule // tb
